// [bench/iso_far_device.sv]
`timescale 1ns/100ps
module iso_far_device (
  input  wire logic       clk_sys,
  input  wire logic       issue_start_split,
  input  wire logic       issue_complete_split,
  input  wire logic [2:0] issue_uframe,
  input  wire logic       in_dir,
  input  wire logic [2:0] delay,
  input  wire logic [7:0] bytes,
  input  wire logic [2:0] flags,
  output logic            xact_done,
  output logic            xact_complete,
  output logic      [2:0] xact_uframe,
  output logic      [2:0] xact_slot,
  output logic      [7:0] xact_bytes,
  output logic            xact_err,
  output logic            xact_babble,
  output logic            xact_underrun
);
  logic       cpl;
  logic [2:0] slot;
  initial begin
    {xact_done, xact_complete, xact_uframe, xact_slot} = 8'h00;
    {xact_bytes, xact_err, xact_babble, xact_underrun} = 11'h000;
    slot = 3'h0;
    forever begin
      @(posedge clk_sys);
      if (issue_start_split || issue_complete_split) begin
        cpl = issue_complete_split;
        xact_uframe <= issue_uframe;
        if (!cpl) slot = issue_uframe;
        repeat (delay) @(posedge clk_sys);
        xact_done     <= 1'b1;
        xact_complete <= cpl;
        xact_slot     <= slot;
        // IN data and flags return with the complete split, OUT error with the start split and OUT underrun with either split
        xact_bytes    <= (in_dir && cpl) ? bytes : 8'h00;
        xact_err      <= flags[0] && (in_dir == cpl);
        xact_babble   <= flags[1] && in_dir && cpl;
        xact_underrun <= flags[2] && !in_dir;
        @(posedge clk_sys);
        xact_done <= 1'b0;
        // Released lines must not keep showing the last value
        xact_bytes <= ~xact_bytes;
        {xact_err, xact_babble, xact_underrun} <= ~{xact_err, xact_babble, xact_underrun};
      end
    end
  end
endmodule

// [bench/split_iso_microframe_tracker_test.sv]
`timescale 1ns/100ps
module split_iso_microframe_tracker_test;
  logic        clk_sys, rst, read, write, uframe_tick, in_dir, irq;
  logic [4:0]  address, bus_frame;
  logic [31:0] writedata, readdata, seed;
  logic [3:0]  byteenable;
  logic        waitrequest, iss, ics, xd, xc, xe, xb, xu;
  logic [2:0]  uframe_idx, iuf, xuf, xsl, delay, flags, fl, fl2, ss_uf, cs_uf;
  logic [7:0]  xby, bytes, b;
  logic [31:0] exp_q[$];
  int          bad_count, check_count, ss_n, cs_n;

  split_iso_microframe_tracker uut (.clk_sys(clk_sys), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .uframe_tick(uframe_tick),
    .uframe_idx(uframe_idx), .bus_frame(bus_frame), .issue_start_split(iss),
    .issue_complete_split(ics), .issue_uframe(iuf), .xact_done(xd), .xact_complete(xc),
    .xact_uframe(xuf), .xact_slot(xsl), .xact_bytes(xby), .xact_err(xe),
    .xact_babble(xb), .xact_underrun(xu));
  iso_far_device far (.clk_sys(clk_sys), .issue_start_split(iss), .issue_complete_split(ics),
    .issue_uframe(iuf), .in_dir(in_dir), .delay(delay), .bytes(bytes), .flags(flags),
    .xact_done(xd), .xact_complete(xc), .xact_uframe(xuf), .xact_slot(xsl),
    .xact_bytes(xby), .xact_err(xe), .xact_babble(xb), .xact_underrun(xu));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    address   <= a;
    write     <= w;
    read      <= !w;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      bad_count++;
      finish_test();
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  task frame(input logic [4:0] f);
    for (int i = 0; i < 8; i++) begin
      uframe_tick <= 1'b1;
      uframe_idx  <= 3'(i);
      bus_frame   <= f;
      @(posedge clk_sys);
      uframe_tick <= 1'b0;
      repeat (14) @(posedge clk_sys);
    end
  endtask

  // Read data are judged at the acking edge, in request order
  always @(posedge clk_sys) begin
    if (read && !waitrequest && exp_q.size() > 0) chk(readdata, exp_q.pop_front());
    if (iss) begin
      ss_n++;
      ss_uf = iuf;
    end
    if (ics) begin
      cs_n++;
      cs_uf = iuf;
    end
  end

  initial begin
    #300000;
    bad_count++;
    finish_test();
  end

  initial begin
    {rst, read, write, uframe_tick, in_dir} = 5'h10;
    {address, bus_frame, uframe_idx, delay, flags} = 19'h00000;
    {writedata, byteenable, bytes} = 44'h000_0000_0f00;
    {ss_n, cs_n, bad_count, check_count} = '0;
    seed = 32'hbbc68f0b;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (b[i]) if (i < 6) rd(5'h00 + 5'(i * 4) + (i == 5 ? 5'h08 : 5'h00), 32'h0);
    seed = xs(seed);
    b  = seed[7:0];
    fl = seed[10:8];
    bytes  <= b;
    flags  <= fl;
    in_dir <= 1'b1;
    bus(split_iso_pkg::OFS_CONFIG, 1'b1, 32'h0000_0017);
    bus(split_iso_pkg::OFS_IRQ_MASK, 1'b1, 32'h0000_000f);
    bus(split_iso_pkg::OFS_MASKS, 1'b1, 32'h0000_0401);
    frame(5'h0b);
    chk(32'(ss_n), 32'h1);
    chk({23'h0, ss_uf, cs_n[0], 2'h0, cs_uf}, {23'h0, 3'h0, 1'b1, 2'h0, 3'h2});
    chk({31'h0, irq}, 32'h1);
    rd(split_iso_pkg::OFS_MASKS, 32'h0);
    rd(split_iso_pkg::OFS_IRQ_STAT, {28'h0, 2'h2, fl[1:0]});
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    seed = xs(seed);
    fl2 = seed[2:0] | 3'h4;
    flags  <= fl2;
    in_dir <= 1'b0;
    delay  <= 3'h7;
    bus(split_iso_pkg::OFS_IRQ_MASK, 1'b1, 32'h0);
    bus(split_iso_pkg::OFS_CONFIG, 1'b1, 32'h0000_0022);
    bus(split_iso_pkg::OFS_MASKS, 1'b1, 32'h0000_0802);
    frame(5'h11);
    chk({31'h0, irq}, 32'h0);
    chk(32'(ss_n + cs_n * 16), 32'h12);
    rd(split_iso_pkg::OFS_MASKS, 32'h0000_0800);
    rd(split_iso_pkg::OFS_STATUS, {6'h0, fl[1], fl[0] | fl2[0], 18'h0, fl2[2], 1'b0,
       fl2[0], 1'b0, fl[1:0]});
    rd(split_iso_pkg::OFS_COUNT_LO, {24'h0, b});
    rd(split_iso_pkg::OFS_IRQ_STAT, {28'h0, 2'h1, 1'b0, fl2[0]});
    bus(split_iso_pkg::OFS_MASKS, 1'b1, 32'h0000_0004);
    frame(5'h12);
    chk(32'(ss_n), 32'h2);
    bus(split_iso_pkg::OFS_MASKS, 1'b1, 32'h0);
    rd(split_iso_pkg::OFS_MASKS, 32'h0000_0804);
    rd(split_iso_pkg::OFS_COUNT_HI, 32'h0);
    // Re-armed slot 1 loses its issued mark, so a stale complete result must not land
    in_dir <= 1'b1;
    bus(split_iso_pkg::OFS_CONFIG, 1'b1, 32'h0000_0023);
    bus(split_iso_pkg::OFS_MASKS, 1'b1, 32'h0000_0102);
    frame(5'h11);
    chk(32'(ss_n + cs_n * 16), 32'h34);
    rd(split_iso_pkg::OFS_COUNT_LO, {8'h00, b, 8'h00, b});
    rd(split_iso_pkg::OFS_STATUS, {6'h0, fl[1] | fl2[1], fl[0] | fl2[0], 15'h0, 1'b0,
       fl2[1:0], fl2[2], 1'b0, fl2[0], 1'b0, fl[1:0]});
    rd(split_iso_pkg::OFS_IRQ_STAT, {28'h0, 1'b1, 1'b0, fl2[1:0]});
    rd(split_iso_pkg::OFS_MASKS, 32'h0);
    finish_test();
  end
endmodule

// [rtl/slot_if.sv]
`timescale 1ns/100ps
interface slot_if;
  logic       wr_status;
  logic       wr_count;
  logic [7:0] count_in;
  logic [2:0] status_in;
  logic [7:0] count;
  logic [2:0] status;

  modport ctrl (output wr_status, output wr_count, output count_in, output status_in,
                input count, input status);
  modport slot (input wr_status, input wr_count, input count_in, input status_in,
                output count, output status);
endinterface

// [rtl/split_iso_microframe_tracker.sv]
`timescale 1ns/100ps
module split_iso_microframe_tracker (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq,
  input  wire logic        uframe_tick,
  input  wire logic [2:0]  uframe_idx,
  input  wire logic [4:0]  bus_frame,
  output logic             issue_start_split,
  output logic             issue_complete_split,
  output logic      [2:0]  issue_uframe,
  input  wire logic        xact_done,
  input  wire logic        xact_complete,
  input  wire logic [2:0]  xact_uframe,
  input  wire logic [2:0]  xact_slot,
  input  wire logic [7:0]  xact_bytes,
  input  wire logic        xact_err,
  input  wire logic        xact_babble,
  input  wire logic        xact_underrun
);
  typedef struct packed {
    logic [7:0]  ss_mask;
    logic [7:0]  cs_mask;
    logic [7:0]  ss_seen;
    logic        dir_in;
    logic [4:0]  frame_no;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        issue_ss;
    logic        issue_cs;
    logic [2:0]  issue_uframe;
  } trk_state_t;

  trk_state_t s_reg;
  trk_state_t s_next;

  slot_if sif [8] ();

  logic [63:0] count_all;
  logic [23:0] status_all;
  logic [31:0] wd_be;
  logic        ack;
  logic        record;
  logic        babble_sum;
  logic        xerr_sum;

  genvar g;
  generate
    for (g = 0; g < split_iso_pkg::UFRAMES; g++) begin : g_slot
      assign sif[g].wr_count  = record && xact_complete && s_reg.dir_in && (xact_slot == g);
      assign sif[g].wr_status = record && (xact_slot == g) &&
                                (xact_complete == s_reg.dir_in);
      assign sif[g].count_in  = xact_bytes;
      // Babble only exists for IN, underrun only for OUT
      assign sif[g].status_in = {xact_underrun && !s_reg.dir_in,
                                 xact_babble && s_reg.dir_in, xact_err};
      assign count_all[g*8 +: 8]  = sif[g].count;
      assign status_all[g*3 +: 3] = sif[g].status;
      uframe_slot u_slot (
        .clk_sys (clk_sys),
        .rst     (rst),
        .port    (sif[g])
      );
    end
  endgenerate

  // Only slots whose start split really went out may be written
  assign record = xact_done && s_reg.ss_seen[xact_slot];

  always_comb begin
    babble_sum = 1'b0;
    xerr_sum   = 1'b0;
    for (int i = 0; i < split_iso_pkg::UFRAMES; i++) begin
      babble_sum = babble_sum | status_all[i*3 + split_iso_pkg::FLD_BABBLE];
      xerr_sum   = xerr_sum | status_all[i*3 + split_iso_pkg::FLD_XERR];
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wd_be[b*8 +: 8] = byteenable[b] ? writedata[b*8 +: 8] : 8'h00;
    end
  end

  assign ack = (read || write) && !s_reg.waitrequest;

  always_comb begin
    logic [3:0] ev;
    ev     = 4'h0;
    s_next = s_reg;
    s_next.issue_ss = 1'b0;
    s_next.issue_cs = 1'b0;
    // One wait state on every access; the answer comes on the second edge
    s_next.waitrequest = !((read || write) && s_reg.waitrequest);

    if (uframe_tick) begin
      s_next.issue_uframe = uframe_idx;
      if (bus_frame == s_reg.frame_no && s_reg.ss_mask[uframe_idx]) begin
        s_next.issue_ss = 1'b1;
        s_next.ss_seen[uframe_idx] = 1'b1;
      end
      if (bus_frame == s_reg.frame_no && s_reg.dir_in && s_reg.cs_mask[uframe_idx]) begin
        s_next.issue_cs = 1'b1;
      end
    end

    if (xact_done) begin
      if (xact_complete) begin
        s_next.cs_mask[xact_uframe] = 1'b0;
      end else begin
        s_next.ss_mask[xact_uframe] = 1'b0;
      end
      ev[split_iso_pkg::IRQ_XERR]     = xact_err;
      ev[split_iso_pkg::IRQ_BABBLE]   = xact_babble && s_reg.dir_in;
      ev[split_iso_pkg::IRQ_UNDERRUN] = xact_underrun && !s_reg.dir_in;
    end

    // Software set follows the hardware clear so a re-arm is never lost
    if (write && ack) begin
      case (address)
        split_iso_pkg::OFS_MASKS: begin
          s_next.ss_mask = s_next.ss_mask | wd_be[split_iso_pkg::MASK_SS_LSB +: 8];
          s_next.ss_seen = s_next.ss_seen & ~wd_be[split_iso_pkg::MASK_SS_LSB +: 8];
          s_next.cs_mask = s_next.cs_mask | wd_be[split_iso_pkg::MASK_CS_LSB +: 8];
        end
        split_iso_pkg::OFS_CONFIG: begin
          if (byteenable[0]) begin
            s_next.dir_in   = writedata[split_iso_pkg::CFG_DIR_IN_BIT];
            s_next.frame_no = writedata[split_iso_pkg::CFG_FRAME_LSB +: 5];
          end
        end
        split_iso_pkg::OFS_IRQ_MASK: begin
          if (byteenable[0]) begin
            s_next.irq_mask = writedata[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (xact_done && s_next.ss_mask == 8'h00 && s_next.cs_mask == 8'h00) begin
      ev[split_iso_pkg::IRQ_DRAINED] = 1'b1;
    end

    // Clear on the capturing edge: an event after the capture must not vanish unread
    if (read && s_reg.waitrequest && address == split_iso_pkg::OFS_IRQ_STAT) begin
      s_next.irq_stat = 4'h0;
    end
    // A new event in the clearing cycle survives the read
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    if (read && s_reg.waitrequest) begin
      case (address)
        split_iso_pkg::OFS_MASKS:    s_next.readdata = {16'h0000, s_reg.cs_mask, s_reg.ss_mask};
        split_iso_pkg::OFS_CONFIG:   s_next.readdata = {26'h0000000, s_reg.frame_no,
                                                        s_reg.dir_in};
        split_iso_pkg::OFS_STATUS:   s_next.readdata = {6'h00, babble_sum, xerr_sum,
                                                        status_all};
        split_iso_pkg::OFS_COUNT_LO: s_next.readdata = count_all[31:0];
        split_iso_pkg::OFS_COUNT_HI: s_next.readdata = count_all[63:32];
        split_iso_pkg::OFS_IRQ_STAT: s_next.readdata = {28'h0000000, s_reg.irq_stat};
        split_iso_pkg::OFS_IRQ_MASK: s_next.readdata = {28'h0000000, s_reg.irq_mask};
        default:                     s_next.readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.ss_mask      <= split_iso_pkg::RST_MASK;
      s_reg.cs_mask      <= split_iso_pkg::RST_MASK;
      s_reg.ss_seen      <= split_iso_pkg::RST_MASK;
      s_reg.dir_in       <= 1'b0;
      s_reg.frame_no     <= split_iso_pkg::RST_FRAME;
      s_reg.irq_stat     <= split_iso_pkg::RST_IRQ;
      s_reg.irq_mask     <= split_iso_pkg::RST_IRQ;
      s_reg.readdata     <= split_iso_pkg::RST_RDATA;
      s_reg.waitrequest  <= 1'b1;
      s_reg.irq          <= 1'b0;
      s_reg.issue_ss     <= 1'b0;
      s_reg.issue_cs     <= 1'b0;
      s_reg.issue_uframe <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata             = s_reg.readdata;
  assign waitrequest          = s_reg.waitrequest;
  assign irq                  = s_reg.irq;
  assign issue_start_split    = s_reg.issue_ss;
  assign issue_complete_split = s_reg.issue_cs;
  assign issue_uframe         = s_reg.issue_uframe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ss_due;
    uframe_tick && bus_frame == s_reg.frame_no && s_reg.ss_mask[uframe_idx];
  endsequence
  sequence cs_due;
    uframe_tick && bus_frame == s_reg.frame_no && s_reg.dir_in && s_reg.cs_mask[uframe_idx];
  endsequence

  start_issue_a: assert property (ss_due |=> issue_start_split &&
    issue_uframe == $past(uframe_idx)) else $error("start split not issued");
  start_gate_a: assert property (issue_start_split |->
    $past(s_reg.ss_mask[uframe_idx])) else $error("start split without mask bit");
  compl_issue_a: assert property (cs_due |=> issue_complete_split)
    else $error("complete split not issued");
  compl_out_a: assert property (issue_complete_split |-> $past(s_reg.dir_in))
    else $error("complete split on OUT transfer");
  compl_clear_a: assert property (xact_done && xact_complete && !write |=>
    !s_reg.cs_mask[$past(xact_uframe)]) else $error("complete mask bit not cleared");
  count_store_a: assert property (record && xact_complete && s_reg.dir_in ##1 1 |->
    count_all[$past(xact_slot)*8 +: 8] == $past(xact_bytes)) else $error("count not stored");
  slot_hold_a: assert property (xact_done && !s_reg.ss_seen[xact_slot] |=>
    $stable(count_all) && $stable(status_all)) else $error("unissued slot changed");
  out_status_a: assert property (record && !xact_complete && !s_reg.dir_in |=>
    status_all[$past(xact_slot)*3 +: 3] == {$past(xact_underrun), 1'b0, $past(xact_err)})
    else $error("OUT status wrong");
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
endmodule

// [rtl/split_iso_pkg.sv]
package split_iso_pkg;

  localparam int UFRAMES = 8;
  localparam int CNT_W   = 8;
  localparam int STAT_W  = 3;
  localparam int FRAME_W = 5;
  localparam int IRQ_W   = 4;

  // Register byte offsets
  localparam logic [4:0] OFS_MASKS     = 5'h00;
  localparam logic [4:0] OFS_CONFIG    = 5'h04;
  localparam logic [4:0] OFS_STATUS    = 5'h08;
  localparam logic [4:0] OFS_COUNT_LO  = 5'h0c;
  localparam logic [4:0] OFS_COUNT_HI  = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT  = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK  = 5'h18;

  // Field positions
  localparam int MASK_SS_LSB    = 0;
  localparam int MASK_CS_LSB    = 8;
  localparam int CFG_DIR_IN_BIT = 0;
  localparam int CFG_FRAME_LSB  = 1;
  localparam int STAT_XERR_BIT  = 24;
  localparam int STAT_BABBLE_BIT = 25;

  // Bits inside one microframe status field
  localparam int FLD_XERR     = 0;
  localparam int FLD_BABBLE   = 1;
  localparam int FLD_UNDERRUN = 2;

  // Interrupt status bits
  localparam int IRQ_XERR     = 0;
  localparam int IRQ_BABBLE   = 1;
  localparam int IRQ_UNDERRUN = 2;
  localparam int IRQ_DRAINED  = 3;

  // Reset values
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [4:0]  RST_FRAME    = 5'h00;
  localparam logic [3:0]  RST_IRQ      = 4'h0;
  localparam logic [7:0]  RST_COUNT    = 8'h00;
  localparam logic [2:0]  RST_STATUS   = 3'h0;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

endpackage

// [rtl/uframe_slot.sv]
`timescale 1ns/100ps
module uframe_slot (
  input  wire logic clk_sys,
  input  wire logic rst,
  slot_if.slot      port
);
  typedef struct packed {
    logic [7:0] count;
    logic [2:0] status;
  } slot_state_t;

  slot_state_t s_reg;
  slot_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (port.wr_status) begin
      s_next.status = port.status_in;
    end
    if (port.wr_count) begin
      s_next.count = port.count_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg.count  <= split_iso_pkg::RST_COUNT;
      s_reg.status <= split_iso_pkg::RST_STATUS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign port.count  = s_reg.count;
  assign port.status = s_reg.status;
endmodule
